// [src/i2c_master_engine.sv]
`default_nettype none
// Behaviour
// - buffer write during a Start is dropped and sets the write collision flag
// - interrupt flag set on start, stop, byte, ack sent, repeated start complete
// - master drives every SCL pulse plus Start and Stop conditions
// - transfer ends with Stop or Repeated Start; restart keeps the bus
// - transmit address byte: 7-bit address then direction bit 0
// - transmit sends 8 bits on SDA, then samples slave acknowledge
// - receive address byte: 7-bit address then direction bit 1
// - receive samples 8 bits while driving SCL, then sends acknowledge
// - baud generator lets SCL run at 100 kHz, 400 kHz or 1 MHz
// - start request is control register two bit 0
// - after Start, interrupt set and other operations held off until hold time
// - slave acknowledge stored in control register two bit 6
// - interrupt set at end of ninth SCL cycle of a byte
// - stop request is bit 2; interrupt only once Stop finished
// - reload value is the low seven bits of baud reload register
// - buffer write starts the baud generator; counts to zero and halts
// - baud count decrements on quarter phase two and four
// - baud generator reloads automatically in master mode
// - when an operation completes the clock halts and SCL holds level
module i2c_master_engine (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START_A = 4'b0001,
        ST_START_B = 4'b0010,
        ST_RSTART_A = 4'b0011,
        ST_RSTART_B = 4'b0100,
        ST_RSTART_C = 4'b0101,
        ST_BIT_LOW = 4'b0110,
        ST_BIT_HIGH = 4'b0111,
        ST_STOP_A = 4'b1000,
        ST_STOP_B = 4'b1001,
        ST_STOP_C = 4'b1010,
        ST_HOLD = 4'b1011
    } phase_t;

    phase_t state_q;
    logic [6:0] baud_reload_q;
    logic [7:0] shift_q;
    logic [7:0] rx_buffer_q;
    logic [3:0] bit_count_q;
    logic receive_byte_q;
    logic start_req_q, restart_req_q, stop_req_q, recv_en_q, ack_en_q;
    logic ack_data_q, ack_stat_q;
    logic irq_flag_q, write_collision_flag_q, buf_full_q;
    logic scl_drive_low_q, sda_drive_low_q;
    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
    logic quarter_tick, baud_expired, baud_reload_pulse;

    // bus pins pass two flops before any logic reads them
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
        end
    end

    // APB decode
    wire apb_write = psel && penable && pwrite;
    wire hit_ctl = (paddr == i2c_master_pkg::ADDR_CONTROL_TWO);
    wire hit_buf = (paddr == i2c_master_pkg::ADDR_TRANSFER_BUF);
    wire hit_baud = (paddr == i2c_master_pkg::ADDR_BAUD_RELOAD);
    wire hit_sts = (paddr == i2c_master_pkg::ADDR_STATUS);
    wire mapped = hit_ctl || hit_buf || hit_baud || hit_sts;
    wire wr_ctl = apb_write && hit_ctl;
    wire wr_buf = apb_write && hit_buf;
    wire wr_baud = apb_write && hit_baud;
    wire wr_sts = apb_write && hit_sts;
    wire rd_buf = psel && penable && !pwrite && hit_buf;
    wire idle_w = (state_q == ST_IDLE);
    // a buffer write only counts while nothing runs; any condition in progress collides
    wire buf_accept = wr_buf && idle_w && !start_req_q && !restart_req_q && !stop_req_q;
    wire buf_collide = wr_buf && !buf_accept;
    wire recv_kick = idle_w && recv_en_q && !buf_full_q;
    wire [31:0] ctl_word = {25'h0, ack_stat_q, ack_data_q, ack_en_q, recv_en_q, stop_req_q,
        restart_req_q, start_req_q};
    wire [31:0] sts_word = {28'h0, buf_full_q, !idle_w, write_collision_flag_q, irq_flag_q};

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = hit_ctl ? ctl_word :
                    hit_buf ? {24'h0, rx_buffer_q} :
                    hit_baud ? {25'h0, baud_reload_q} :
                    hit_sts ? sts_word : 32'h0000_0000;

    phase_tick #(
        .DIVIDE(i2c_master_pkg::QUARTER_DIVIDE)
    ) u_quarter (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(quarter_tick)
    );

    // every state change that waits a baud period restarts the count by itself
    baud_counter #(
        .WIDTH(i2c_master_pkg::BAUD_WIDTH)
    ) u_baud (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .tick(quarter_tick),
        .reload(baud_reload_pulse),
        .reload_value(baud_reload_q),
        .expired(baud_expired)
    );

    // SCL high phase stretches while a slave holds the line low
    wire scl_released_low = (state_q == ST_BIT_HIGH) && !scl_s2_q;
    wire step = !idle_w && baud_expired && !scl_released_low;
    wire bit_last = (bit_count_q == 4'd8);
    wire bit_sda_low = bit_last ? (receive_byte_q && ack_en_q && !ack_data_q) :
                                  (!shift_q[7] && !receive_byte_q);
    wire start_go = idle_w && start_req_q;
    wire restart_go = idle_w && restart_req_q;
    wire stop_go = idle_w && stop_req_q;
    wire byte_go = buf_accept || recv_kick;
    assign baud_reload_pulse = start_go || restart_go || stop_go || byte_go || step;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            baud_reload_q <= i2c_master_pkg::BAUD_RELOAD_RESET;
        else if (wr_baud)
            baud_reload_q <= pwdata[6:0];
    end

    // control bits: software sets; hardware clears start, restart and stop when the condition ends, and recv when the receive starts
    wire start_done = step && (state_q == ST_HOLD) && start_req_q;
    wire restart_done = step && (state_q == ST_HOLD) && restart_req_q;
    wire stop_done = step && (state_q == ST_STOP_C);
    wire byte_done = step && (state_q == ST_BIT_HIGH) && bit_last;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            start_req_q <= 1'b0;
            restart_req_q <= 1'b0;
            stop_req_q <= 1'b0;
            recv_en_q <= 1'b0;
            ack_en_q <= 1'b0;
            ack_data_q <= 1'b0;
        end
        else
        begin
            if (start_done)
                start_req_q <= 1'b0;
            else if (wr_ctl && idle_w)
                start_req_q <= pwdata[i2c_master_pkg::CTL_START_BIT];
            if (restart_done)
                restart_req_q <= 1'b0;
            else if (wr_ctl && idle_w)
                restart_req_q <= pwdata[i2c_master_pkg::CTL_RESTART_BIT];
            if (stop_done)
                stop_req_q <= 1'b0;
            else if (wr_ctl && idle_w)
                stop_req_q <= pwdata[i2c_master_pkg::CTL_STOP_BIT];
            if (byte_go && recv_kick)
                recv_en_q <= 1'b0;
            else if (wr_ctl && idle_w)
                recv_en_q <= pwdata[i2c_master_pkg::CTL_RECV_BIT];
            if (wr_ctl)
                ack_data_q <= pwdata[i2c_master_pkg::CTL_ACK_DATA_BIT];
            if (wr_ctl)
                ack_en_q <= pwdata[i2c_master_pkg::CTL_ACK_SEND_BIT];
        end
    end

    // status flags: the hardware set wins over a software clear in the same cycle
    wire irq_event = start_done || restart_done || stop_done || byte_done;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            irq_flag_q <= 1'b0;
            write_collision_flag_q <= 1'b0;
        end
        else
        begin
            if (irq_event)
                irq_flag_q <= 1'b1;
            else if (wr_sts && !pwdata[i2c_master_pkg::STS_IRQ_BIT])
                irq_flag_q <= 1'b0;
            if (buf_collide)
                write_collision_flag_q <= 1'b1;
            else if (wr_sts && !pwdata[i2c_master_pkg::STS_WRITE_COLLISION_FLAG_BIT])
                write_collision_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            buf_full_q <= 1'b0;
        else if (byte_done && receive_byte_q)
            buf_full_q <= 1'b1;
        else if (rd_buf)
            buf_full_q <= 1'b0;
    end

    // sequencer; scl only changes on a step, so it holds its level when the counter halts
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_IDLE;
            scl_drive_low_q <= 1'b0;
            sda_drive_low_q <= 1'b0;
            shift_q <= 8'h00;
            rx_buffer_q <= 8'h00;
            bit_count_q <= 4'd0;
            receive_byte_q <= 1'b0;
            ack_stat_q <= 1'b0;
        end
        else if (idle_w)
        begin
            if (start_go)
            begin
                state_q <= ST_START_A;
                sda_drive_low_q <= 1'b0;
            end
            else if (restart_go)
                state_q <= ST_RSTART_A;
            else if (stop_go)
            begin
                state_q <= ST_STOP_A;
                sda_drive_low_q <= 1'b1;
            end
            else if (byte_go)
            begin
                // buffer byte carries address and direction bit as software wrote it
                shift_q <= buf_accept ? pwdata[7:0] : 8'hFF;
                receive_byte_q <= recv_kick;
                bit_count_q <= 4'd0;
                state_q <= ST_BIT_LOW;
            end
        end
        else if (step)
        begin
            unique case (state_q)
                ST_START_A:
                begin
                    sda_drive_low_q <= 1'b1;
                    state_q <= ST_START_B;
                end
                ST_START_B:
                begin
                    scl_drive_low_q <= 1'b1;
                    state_q <= ST_HOLD;
                end
                ST_RSTART_A:
                begin
                    sda_drive_low_q <= 1'b0;
                    state_q <= ST_RSTART_B;
                end
                ST_RSTART_B:
                begin
                    scl_drive_low_q <= 1'b0;
                    state_q <= ST_RSTART_C;
                end
                ST_RSTART_C:
                begin
                    sda_drive_low_q <= 1'b1;
                    // the repeated start then pulls scl low like a first start
                    state_q <= ST_START_B;
                end
                ST_HOLD:
                    state_q <= ST_IDLE;
                ST_BIT_LOW:
                begin
                    scl_drive_low_q <= 1'b0;
                    state_q <= ST_BIT_HIGH;
                end
                ST_BIT_HIGH:
                begin
                    // scl stays low after the ninth pulse, so a following byte starts from a low clock
                    scl_drive_low_q <= 1'b1;
                    if (bit_last)
                    begin
                        if (!receive_byte_q)
                            ack_stat_q <= sda_s2_q;
                        else
                            rx_buffer_q <= shift_q;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        shift_q <= {shift_q[6:0], sda_s2_q};
                        bit_count_q <= bit_count_q + 4'd1;
                        state_q <= ST_BIT_LOW;
                    end
                end
                ST_STOP_A:
                begin
                    scl_drive_low_q <= 1'b0;
                    state_q <= ST_STOP_B;
                end
                ST_STOP_B:
                begin
                    sda_drive_low_q <= 1'b0;
                    state_q <= ST_STOP_C;
                end
                ST_STOP_C:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
        // data moves one cycle after scl has fallen, so it never races the clock edge
        else if (state_q == ST_BIT_LOW)
            sda_drive_low_q <= bit_sda_low;
    end

    assign scl_out = 1'b0;
    assign scl_oe = scl_drive_low_q;
    assign sda_out = 1'b0;
    assign sda_oe = sda_drive_low_q;
endmodule : i2c_master_engine
`default_nettype wire

// [src/i2c_master_pkg.sv]
`default_nettype none
package i2c_master_pkg;
    // register byte addresses on the APB
    localparam logic [7:0] ADDR_CONTROL_TWO = 8'h00;
    localparam logic [7:0] ADDR_TRANSFER_BUF = 8'h04;
    localparam logic [7:0] ADDR_BAUD_RELOAD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    // control_reg_two fields
    localparam int CTL_START_BIT = 0;
    localparam int CTL_RESTART_BIT = 1;
    localparam int CTL_STOP_BIT = 2;
    localparam int CTL_RECV_BIT = 3;
    localparam int CTL_ACK_SEND_BIT = 4;
    localparam int CTL_ACK_DATA_BIT = 5;
    localparam int CTL_ACK_STAT_BIT = 6;
    // status register fields
    localparam int STS_IRQ_BIT = 0;
    localparam int STS_WRITE_COLLISION_FLAG_BIT = 1;
    localparam int STS_BUSY_BIT = 2;
    localparam int STS_FULL_BIT = 3;
    // reset values
    localparam logic [6:0] BAUD_RELOAD_RESET = 7'h09;
    localparam int BAUD_WIDTH = 7;
    localparam int BITS_PER_BYTE = 8;
    // the baud generator is stepped twice per instruction cycle of four ref_clk cycles
    localparam int QUARTER_DIVIDE = 2;
endpackage : i2c_master_pkg
`default_nettype wire

// [src/phase_tick.sv]
`default_nettype none
// one-cycle pulse every DIVIDE clocks: stands in for the two quarter phases
module phase_tick #(
    parameter int DIVIDE = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    output logic tick
);
    logic [7:0] count_q;
    wire last_w = (count_q == 8'(DIVIDE - 1));
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || last_w)
            count_q <= 8'h00;
        else
            count_q <= count_q + 8'h01;
    end
    assign tick = last_w;
endmodule : phase_tick
`default_nettype wire

// [src/baud_counter.sv]
`default_nettype none
// counts down from reload to zero on each tick, then halts until reloaded
module baud_counter #(
    parameter int WIDTH = 7
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic reload,
    input wire logic [WIDTH-1:0] reload_value,
    output logic expired
);
    logic [WIDTH-1:0] count_q;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            count_q <= '0;
        else if (reload)
            count_q <= reload_value;
        else if (tick && count_q != '0)
            count_q <= count_q - WIDTH'(1);
    end
    // expired must not look at reload: the sequencer builds reload from expired
    assign expired = (count_q == '0);
endmodule : baud_counter
`default_nettype wire

// [sim/i2c_master_engine_properties.sv]
`default_nettype none
module i2c_master_engine_checker (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    wire logic ctl_wr = psel && penable && pwrite && paddr == i2c_master_pkg::ADDR_CONTROL_TWO;
    ready_high_a: assert property (pready) else $error("pready low");
    slverr_map_a: assert property (psel && penable |-> pslverr == !(paddr < 8'h10 && paddr[1:0] == 2'h0))
        else $error("pslverr wrong");
    open_drain_a: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    reset_idle_a: assert property ($past(sys_rst) |-> !scl_oe && !sda_oe) else $error("line pulled after reset");
    // a bus condition is sda moving while the master leaves scl released
    start_req_a: assert property (ctl_wr && pwdata[0] |-> ##[1:900] ($rose(sda_oe) && !scl_oe))
        else $error("no start condition");
    restart_req_a: assert property (ctl_wr && pwdata[1] |-> ##[1:900] ($rose(sda_oe) && !scl_oe))
        else $error("no repeated start");
    stop_req_a: assert property (ctl_wr && pwdata[2] |-> ##[1:900] ($fell(sda_oe) && !scl_oe))
        else $error("no stop condition");
    start_clock_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:600] $rose(scl_oe))
        else $error("no clock after start");
    // a reload of two or more gives every scl phase at least four cycles
    scl_high_min_a: assert property ($fell(scl_oe) |=> !scl_oe [*3])
        else $error("scl high phase short");
    scl_low_min_a: assert property ($rose(scl_oe) |=> scl_oe [*3])
        else $error("scl low phase short");
endmodule : i2c_master_engine_checker
bind i2c_master_engine i2c_master_engine_checker checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe));
`default_nettype wire

// [sim/i2c_slave_model.sv]
`default_nettype none
// target on the two-wire bus; never stretches scl, so the master alone times every pulse
module i2c_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] tx_byte,
    output logic sda_pull,
    output logic rx_stb,
    output logic [7:0] rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh = 8'h00;
    logic [7:0] nb = 8'h00;
    logic [3:0] k = 4'h0;
    logic on = 1'b0;
    logic adr = 1'b0;
    logic rd = 1'b0;
    logic hit = 1'b0;
    wire logic [7:0] tx = tx_byte + nb;
    initial
    begin
        sda_pull = 1'b0;
        rx_stb = 1'b0;
        rx_byte = 8'h00;
    end
    always @(negedge sda)
        if (scl)
        begin
            on = 1'b1;
            adr = 1'b1;
            rd = 1'b0;
            hit = 1'b0;
            k = 4'h0;
            nb = 8'h00;
        end
    always @(posedge sda)
        if (scl)
            on = 1'b0;
    always @(posedge scl)
        if (on)
        begin
            if (k < 4'h8)
                sh = {sh[6:0], sda};
            if (k == 4'h7 && !rd || k == 4'h8 && rd && !adr)
            begin
                rx_byte = (k == 4'h8) ? {7'h00, sda} : sh;
                rx_stb = 1'b1;
                #1 rx_stb = 1'b0;
            end
            if (k == 4'h7 && adr)
            begin
                hit = sh[7:1] == ADDR;
                rd = sh[0];
            end
            // a master nack ends the read, so the line is free for the stop
            if (k == 4'h8 && rd && !adr)
            begin
                nb = nb + 8'h01;
                hit = hit && !sda;
            end
            adr = adr && k != 4'h8;
            k = (k == 4'h8) ? 4'h0 : k + 4'h1;
        end
    always @(negedge scl)
        sda_pull = on && hit && ((k == 4'h8) ? (adr || !rd) : (rd && !adr && !tx[~k[2:0]]));
endmodule : i2c_slave_model
`default_nettype wire

// [sim/i2c_master_engine_test.sv]
`default_nettype none
module i2c_master_engine_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string name; logic [31:0] mask; logic [31:0] value;} exp_t;
    localparam logic [6:0] SLAVE_ADDR = 7'h2A;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic rd_chk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] tx_byte = 8'h00;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, sda_pull, rx_stb;
    logic [7:0] rx_byte;
    int errors = 0;
    int n_compared = 0;
    int seed = 33;
    exp_t q[$];
    // both lines have pull-ups: released means high
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || sda_pull);
    always #5 ref_clk = ~ref_clk;
    i2c_master_engine dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
    i2c_slave_model #(.ADDR(SLAVE_ADDR)) slave (.scl(scl_w), .sda(sda_w), .tx_byte(tx_byte),
        .sda_pull(sda_pull), .rx_stb(rx_stb), .rx_byte(rx_byte));
    task automatic give_verdict();
        // a result that never arrived leaves its note behind
        if (q.size() != 0)
            errors++;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    task automatic compare(input logic [31:0] seen);
        exp_t e;
        if (q.size() == 0)
            q.push_back('{"surplus result", 32'h0, 32'h1});
        e = q.pop_front();
        n_compared++;
        if ((seen & e.mask) !== e.value)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", e.name, e.value, seen & e.mask);
        end
    endtask : compare
    always @(posedge ref_clk)
        if (psel && penable && !pwrite && rd_chk)
            compare(prdata);
    always @(posedge rx_stb)
        compare({24'h0, rx_byte});
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic chk);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        rd_chk <= chk;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        rd_chk <= 1'b0;
        if (pready !== 1'b1)
        begin
            errors++;
            $display("wrong value pready expected 1 seen %b", pready);
            give_verdict();
        end
        @(posedge ref_clk);
    endtask : apb
    task automatic check(input logic [7:0] a, input string s, input logic [31:0] m, input logic [31:0] v);
        q.push_back('{s, m, v});
        apb(1'b0, a, 32'h0, 1'b1);
    endtask : check
    task automatic wait_irq();
        int n;
        n = 0;
        rdata = 32'h0;
        while (rdata[i2c_master_pkg::STS_IRQ_BIT] !== 1'b1 && n < 2000)
        begin
            apb(1'b0, i2c_master_pkg::ADDR_STATUS, 32'h0, 1'b0);
            n++;
        end
        if (rdata[i2c_master_pkg::STS_IRQ_BIT] !== 1'b1)
        begin
            errors++;
            $display("wrong value irq flag expected 1 seen %b", rdata[i2c_master_pkg::STS_IRQ_BIT]);
            give_verdict();
        end
        // writing zero clears the irq and the collision flag alike
        apb(1'b1, i2c_master_pkg::ADDR_STATUS, 32'h0, 1'b0);
    endtask : wait_irq
    task automatic send(input logic [7:0] b, input logic nack);
        q.push_back('{"slave byte", 32'hFF, {24'h0, b}});
        apb(1'b1, i2c_master_pkg::ADDR_TRANSFER_BUF, {24'h0, b}, 1'b0);
        wait_irq();
        check(i2c_master_pkg::ADDR_CONTROL_TWO, "ack status", 32'h40, {25'h0, nack, 6'h0});
    endtask : send
    initial
    begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        check(i2c_master_pkg::ADDR_BAUD_RELOAD, "baud reset", 32'hFF, 32'h09);
        check(i2c_master_pkg::ADDR_STATUS, "status reset", 32'hF, 32'h0);
        check(i2c_master_pkg::ADDR_CONTROL_TWO, "control reset", 32'h7F, 32'h0);
        apb(1'b1, i2c_master_pkg::ADDR_BAUD_RELOAD, 32'hFF, 1'b0);
        check(i2c_master_pkg::ADDR_BAUD_RELOAD, "baud width", 32'hFF, 32'h7F);
        apb(1'b0, 8'h10, 32'h0, 1'b0);
        apb(1'b1, i2c_master_pkg::ADDR_BAUD_RELOAD, 32'({$random(seed)} % 6 + 2), 1'b0);
        $display("registers test done");
        apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, 32'h1, 1'b0);
        apb(1'b1, i2c_master_pkg::ADDR_TRANSFER_BUF, 32'h55, 1'b0);
        check(i2c_master_pkg::ADDR_STATUS, "collision flag", 32'h2, 32'h2);
        wait_irq();
        check(i2c_master_pkg::ADDR_CONTROL_TWO, "start bit", 32'h1, 32'h0);
        send({SLAVE_ADDR, 1'b0}, 1'b0);
        for (int i = 0; i < 2; i++)
            send(8'($random(seed)), 1'b0);
        apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, 32'h2, 1'b0);
        wait_irq();
        send({~SLAVE_ADDR, 1'b0}, 1'b1);
        apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, 32'h4, 1'b0);
        wait_irq();
        check(i2c_master_pkg::ADDR_CONTROL_TWO, "stop bit", 32'h4, 32'h0);
        $display("write test done");
        tx_byte <= 8'($random(seed));
        apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, 32'h1, 1'b0);
        wait_irq();
        send({SLAVE_ADDR, 1'b1}, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            q.push_back('{"master ack", 32'hFF, {31'h0, i[0]}});
            apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, i ? 32'h38 : 32'h18, 1'b0);
            wait_irq();
            check(i2c_master_pkg::ADDR_TRANSFER_BUF, "received byte", 32'hFF, {24'h0, tx_byte + 8'(i)});
        end
        apb(1'b1, i2c_master_pkg::ADDR_CONTROL_TWO, 32'h4, 1'b0);
        wait_irq();
        $display("read test done");
        give_verdict();
    end
endmodule : i2c_master_engine_test
`default_nettype wire
